// *** hdl/vapf_cfg.svh ***
// constants of the vbi ancillary packet framer: register map, packet layout, codes
// assumes inclusion by bare name from the package and the design file
`ifndef VAPF_CFG_SVH
`define VAPF_CFG_SVH

// register byte offsets (word aligned)
`define VAPF_ADR_CTRL 8'h00
`define VAPF_ADR_STATUS 8'h04
`define VAPF_ADR_MASK 8'h08
`define VAPF_ADR_LEVEL 8'h0c
`define VAPF_ADR_READBACK 8'h10
`define VAPF_ADR_RATING 8'h14
// line mode table starts where address bit 7 is set, one word per line
`define VAPF_ADR_TABLE_BIT 7

// control fields
`define VAPF_CTRL_EN 0
`define VAPF_CTRL_STD_LO 1
`define VAPF_CTRL_STD_HI 2
`define VAPF_STD_NTSC 2'h0
`define VAPF_STD_PAL 2'h1
`define VAPF_STD_SECAM 2'h2

// status / mask bits
`define VAPF_ST_STORED 0
`define VAPF_ST_SENT 1
`define VAPF_ST_DROP 2

// line mode fields
`define VAPF_MODE_FMT_HI 2
`define VAPF_MODE_TO_FIFO 3
`define VAPF_MODE_TO_RB 4
`define VAPF_FMT_NONE 3'h0
`define VAPF_FMT_TTX 3'h1
`define VAPF_FMT_RATING 3'h6

// packet layout
`define VAPF_PRE_ZERO 8'h00
`define VAPF_PRE_ONES 8'hff
`define VAPF_OFS_PRE1 9'd1
`define VAPF_OFS_PRE2 9'd2
`define VAPF_OFS_TYPE 9'd3
`define VAPF_OFS_FMT 9'd4
`define VAPF_OFS_CNT 9'd5
`define VAPF_OFS_LLO 9'd6
`define VAPF_OFS_INFO 9'd7
`define VAPF_OFS_DATA 9'd8
`define VAPF_HDR_LEN 9'd8
`define VAPF_FILL_MAX 3
`define VAPF_TYPE_MID 3'h2
`define VAPF_TYPE_F1_VBI 3'h1
`define VAPF_TYPE_F2_VBI 3'h5
`define VAPF_TYPE_F1_LATE 3'h3
`define VAPF_TYPE_F2_LATE 3'h7
`define VAPF_LATE_LINE 10'd24
`define VAPF_RB_BYTES 6'd4

// payload limits
`define VAPF_MAX_DATA 6'd43
`define VAPF_RESERVE 10'd56
`define VAPF_TTX_NTSC_FIRST 10'd10
`define VAPF_TTX_NTSC_LAST 10'd21
`define VAPF_TTX_NTSC_BYTES 6'd34
`define VAPF_TTX_PAL_FIRST 10'd6
`define VAPF_TTX_PAL_LAST 10'd22
`define VAPF_TTX_PAL_BYTES 6'd43
`define VAPF_TTX_SECAM_LAST 10'd23
`define VAPF_TTX_SECAM_BYTES 6'd38

`endif

// *** hdl/vapf_pkg.sv ***
// types of the vbi ancillary packet framer
// assumes vapf_cfg.svh on the include path
`include "vapf_cfg.svh"

package vapf_pkg;
  typedef enum logic {
    VAPF_TX_IDLE,
    VAPF_TX_SEND
  } vapf_tx_e;
endpackage : vapf_pkg

// *** hdl/vapf_framer.sv ***
// vbi ancillary packet framer: packs sliced line data into ancillary packets, keeps them in a
// flip-flop buffer and inserts them on the upper luma byte during horizontal blanking.
// assumes slicer strobes on CLK, a free running pixel clock and blanking level from pins.
// Contract
// - packets go on upper luma byte only in horizontal blanking, BT.656 enabled
// - buffer holds 512 bytes in the same layout as sent
// - preamble 00 ff ff, then type, line format, word count bytes
// - bit 6 even parity of bits 5..0, bit 7 its inverse
// - type 91h/55h for vbi lines, 53h/97h from line 24, per field
// - line format byte carries line mode bits 2..0
// - word count gives four-byte words from byte 8 to packet end
// - byte 6 line number low byte, byte 7 bits 1..0 line number top
// - byte 7 bit 2 match two, bit 3 match one, bit 4 error
// - checksum byte after data sums type byte through last data byte
// - zero fill bytes pad packet to multiple of four bytes
// - teletext sync byte at packet byte 8, payload from byte 9
// - each line has its own service selection, one service per line; only lines 0..31 have a table entry, later lines get none
// - results to buffer, readback or both; teletext to buffer only
// - decoded parental rating bytes go to a dedicated register
// - teletext lines and byte counts follow the selected standard
//
// Chosen here: the address map and the Wishbone slave port.
`include "vapf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module vapf_framer
  import vapf_pkg::*;
#(
  parameter int DEPTH = 512,
  parameter int LINES = 32,
  parameter logic [8:0] HBLANK_SLOTS = 9'd268
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  output logic [31:0] DAT_O,
  output logic IRQ,
  input wire logic SL_START,
  input wire logic [9:0] SL_LINE,
  input wire logic SL_FIELD,
  input wire logic SL_MATCH1,
  input wire logic SL_MATCH2,
  input wire logic SL_BYTE_VALID,
  input wire logic [7:0] SL_BYTE,
  input wire logic SL_END,
  input wire logic SL_ERROR,
  input wire logic PIX_CLK,
  input wire logic HBLANK,
  output logic [7:0] Y_ANC,
  output logic Y_ANC_EN
);

  localparam int PW = $clog2(DEPTH) + 1;
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(LINES);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [LINES-1:0][4:0] mode;
    logic [2:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [PW-1:0] commit;
    logic [PW-1:0] rd;
    logic cap_on;
    logic cap_fifo;
    logic cap_rb;
    logic cap_rate;
    logic [9:0] cap_line;
    logic cap_m1;
    logic cap_m2;
    logic [5:0] cap_cnt;
    logic [5:0] cap_lim;
    logic [PW-1:0] cap_base;
    logic [7:0] cap_sum;
    logic [3:0][7:0] rb_buf;
    logic [31:0] readback;
    logic [31:0] rating;
    logic [2:0] clk_sync;
    logic [2:0] blk_sync;
    logic clk_f;
    logic blk_f;
    vapf_tx_e tx;
    logic [8:0] tx_left;
    logic [7:0] y;
    logic y_en;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } vapf_state_s;

  vapf_state_s s;
  vapf_state_s next_s;

  // buffer slot of packet byte off counted from base
  function automatic logic [AW-1:0] vapf_idx(input logic [PW-1:0] base, input logic [8:0] off);
    vapf_idx = AW'(base[AW-1:0] + off[AW-1:0]);
  endfunction : vapf_idx

  function automatic logic [7:0] vapf_par(input logic [5:0] v);
    logic ep;
    ep = ^v;
    vapf_par = {~ep, ep, v};
  endfunction : vapf_par

  function automatic logic [31:0] vapf_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    vapf_merge = r;
  endfunction : vapf_merge

  // teletext byte count for the line, zero when the line is outside the capture range
  function automatic logic [5:0] vapf_ttx_len(input logic [1:0] std, input logic [9:0] line);
    logic [5:0] r;
    r = 6'h00;
    unique case (std)
      `VAPF_STD_NTSC: begin
        if (line >= `VAPF_TTX_NTSC_FIRST && line <= `VAPF_TTX_NTSC_LAST) r = `VAPF_TTX_NTSC_BYTES;
      end
      `VAPF_STD_PAL: begin
        if (line >= `VAPF_TTX_PAL_FIRST && line <= `VAPF_TTX_PAL_LAST) r = `VAPF_TTX_PAL_BYTES;
      end
      `VAPF_STD_SECAM: begin
        if (line >= `VAPF_TTX_PAL_FIRST && line <= `VAPF_TTX_SECAM_LAST) r = `VAPF_TTX_SECAM_BYTES;
      end
      default: r = 6'h00;
    endcase
    vapf_ttx_len = r;
  endfunction : vapf_ttx_len

  always_comb begin
    logic [2:0] ev;
    logic [4:0] lmode;
    logic [2:0] fmt;
    logic ttx;
    logic [PW-1:0] level;
    logic [2:0] tcode;
    logic [7:0] tbyte;
    logic [7:0] fbyte;
    logic [7:0] cbyte;
    logic [7:0] ibyte;
    logic [6:0] words;
    logic [8:0] plen;
    logic [8:0] dofs;
    logic acc;
    logic rd_status;
    logic clk_rise;
    logic blk_rise;
    ev = 3'h0;
    lmode = 5'h00;
    fmt = `VAPF_FMT_NONE;
    ttx = 1'b0;
    tcode = `VAPF_TYPE_F1_VBI;
    tbyte = 8'h00;
    fbyte = 8'h00;
    cbyte = 8'h00;
    ibyte = 8'h00;
    words = 7'h00;
    plen = 9'h000;
    dofs = 9'h000;
    clk_rise = 1'b0;
    blk_rise = 1'b0;
    next_s = s;
    level = PW'(s.commit - s.rd);
    acc = CYC_I && STB_I && !s.ack;
    rd_status = acc && !WE_I && ADR_I == `VAPF_ADR_STATUS;

    // capture: line start writes the fixed header
    if (SL_START) begin
      if (SL_LINE < 10'(LINES)) begin
        lmode = s.mode[SL_LINE[LW-1:0]];
      end
      fmt = lmode[`VAPF_MODE_FMT_HI:0];
      ttx = fmt == `VAPF_FMT_TTX;
      next_s.cap_fifo = lmode[`VAPF_MODE_TO_FIFO] || ttx;
      next_s.cap_rb = lmode[`VAPF_MODE_TO_RB] && !ttx;
      next_s.cap_rate = fmt == `VAPF_FMT_RATING;
      next_s.cap_lim = ttx ? vapf_ttx_len(s.ctrl[`VAPF_CTRL_STD_HI:`VAPF_CTRL_STD_LO], SL_LINE) : `VAPF_MAX_DATA;
      if (PW'(DEPTH) - level < `VAPF_RESERVE && next_s.cap_fifo) begin
        next_s.cap_fifo = 1'b0;
        ev[`VAPF_ST_DROP] = 1'b1;
      end
      next_s.cap_on = fmt != `VAPF_FMT_NONE && next_s.cap_lim != 6'h00 &&
                      (next_s.cap_fifo || next_s.cap_rb || next_s.cap_rate);
      next_s.cap_line = SL_LINE;
      next_s.cap_m1 = SL_MATCH1;
      next_s.cap_m2 = SL_MATCH2;
      next_s.cap_cnt = 6'h00;
      next_s.cap_base = s.commit;
      next_s.rb_buf = '0;
      if (SL_LINE >= `VAPF_LATE_LINE) begin
        tcode = SL_FIELD ? `VAPF_TYPE_F2_LATE : `VAPF_TYPE_F1_LATE;
      end else begin
        tcode = SL_FIELD ? `VAPF_TYPE_F2_VBI : `VAPF_TYPE_F1_VBI;
      end
      tbyte = vapf_par({`VAPF_TYPE_MID, tcode});
      fbyte = vapf_par({3'h0, fmt});
      next_s.cap_sum = 8'(tbyte + fbyte + SL_LINE[7:0]);
      if (next_s.cap_on && next_s.cap_fifo) begin
        next_s.mem[vapf_idx(s.commit, 9'h000)] = `VAPF_PRE_ZERO;
        next_s.mem[vapf_idx(s.commit, `VAPF_OFS_PRE1)] = `VAPF_PRE_ONES;
        next_s.mem[vapf_idx(s.commit, `VAPF_OFS_PRE2)] = `VAPF_PRE_ONES;
        next_s.mem[vapf_idx(s.commit, `VAPF_OFS_TYPE)] = tbyte;
        next_s.mem[vapf_idx(s.commit, `VAPF_OFS_FMT)] = fbyte;
        next_s.mem[vapf_idx(s.commit, `VAPF_OFS_LLO)] = SL_LINE[7:0];
      end
    end else begin
      // payload bytes, first one lands at byte 8 (teletext sync byte)
      if (s.cap_on && SL_BYTE_VALID && s.cap_cnt < s.cap_lim) begin
        dofs = `VAPF_OFS_DATA + 9'(s.cap_cnt);
        if (s.cap_fifo) begin
          next_s.mem[vapf_idx(s.cap_base, dofs)] = SL_BYTE;
        end
        if (s.cap_cnt < `VAPF_RB_BYTES) begin
          next_s.rb_buf[s.cap_cnt[1:0]] = SL_BYTE;
        end
        next_s.cap_sum = 8'(s.cap_sum + SL_BYTE);
        next_s.cap_cnt = 6'(s.cap_cnt + 6'h01);
      end
      // line end: word count, info byte, checksum, fill, then commit
      if (s.cap_on && SL_END) begin
        next_s.cap_on = 1'b0;
        words = 7'((7'(next_s.cap_cnt) + 7'h04) >> 2);
        cbyte = vapf_par(words[5:0]);
        ibyte = {3'h0, SL_ERROR, s.cap_m1, s.cap_m2, s.cap_line[9:8]};
        if (s.cap_fifo) begin
          dofs = `VAPF_OFS_DATA + 9'(next_s.cap_cnt);
          next_s.mem[vapf_idx(s.cap_base, `VAPF_OFS_CNT)] = cbyte;
          next_s.mem[vapf_idx(s.cap_base, `VAPF_OFS_INFO)] = ibyte;
          next_s.mem[vapf_idx(s.cap_base, dofs)] = 8'(next_s.cap_sum + cbyte + ibyte);
          for (int f = 1; f <= `VAPF_FILL_MAX; f++) begin
            next_s.mem[vapf_idx(s.cap_base, 9'(dofs + 9'(f)))] = 8'h00;
          end
          next_s.commit = PW'(s.cap_base + PW'(`VAPF_HDR_LEN) + PW'({words, 2'b00}));
          ev[`VAPF_ST_STORED] = 1'b1;
        end
        if (s.cap_rb) begin
          next_s.readback = s.rb_buf;
        end
        if (s.cap_rate) begin
          next_s.rating = s.rb_buf;
        end
      end
    end

    // link side: three stage samplers, a change counts once stages two and three agree
    next_s.clk_sync = {s.clk_sync[1:0], PIX_CLK};
    next_s.blk_sync = {s.blk_sync[1:0], HBLANK};
    if (s.clk_sync[1] == s.clk_sync[2]) begin
      next_s.clk_f = s.clk_sync[2];
    end
    if (s.blk_sync[1] == s.blk_sync[2]) begin
      next_s.blk_f = s.blk_sync[2];
    end
    clk_rise = next_s.clk_f && !s.clk_f;
    blk_rise = next_s.blk_f && !s.blk_f;

    unique case (s.tx)
      VAPF_TX_IDLE: begin
        plen = 9'({s.mem[vapf_idx(s.rd, `VAPF_OFS_CNT)][5:0], 2'b00}) + `VAPF_HDR_LEN;
        // one whole packet per blanking, only if it fits in the slots
        if (blk_rise && s.ctrl[`VAPF_CTRL_EN] && level != '0 && plen <= HBLANK_SLOTS) begin
          next_s.tx = VAPF_TX_SEND;
          next_s.tx_left = plen;
        end
        if (clk_rise) begin
          next_s.y_en = 1'b0;
          next_s.y = 8'h00;
        end
      end
      VAPF_TX_SEND: begin
        if (!next_s.blk_f) begin
          next_s.tx = VAPF_TX_IDLE;
          next_s.y_en = 1'b0;
          next_s.y = 8'h00;
        end else if (clk_rise) begin
          next_s.y = s.mem[s.rd[AW-1:0]];
          next_s.y_en = 1'b1;
          next_s.rd = PW'(s.rd + PW'(1));
          next_s.tx_left = 9'(s.tx_left - 9'h001);
          if (s.tx_left == 9'h001) begin
            next_s.tx = VAPF_TX_IDLE;
            ev[`VAPF_ST_SENT] = 1'b1;
          end
        end
      end
    endcase

    // wishbone classic slave, ack one cycle after the request is seen
    next_s.ack = acc;
    if (acc) begin
      next_s.dat = 32'h0000_0000;
      if (ADR_I[`VAPF_ADR_TABLE_BIT]) begin
        if (ADR_I[LW+1:2] < LW'(LINES - 1) || ADR_I[LW+1:2] == LW'(LINES - 1)) begin
          next_s.dat = 32'(s.mode[ADR_I[LW+1:2]]);
          if (WE_I) begin
            next_s.mode[ADR_I[LW+1:2]] = 5'(vapf_merge(32'(s.mode[ADR_I[LW+1:2]]), DAT_I, SEL_I));
          end
        end
      end else begin
        unique case (ADR_I)
          `VAPF_ADR_CTRL: begin
            next_s.dat = 32'(s.ctrl);
            if (WE_I) next_s.ctrl = 3'(vapf_merge(32'(s.ctrl), DAT_I, SEL_I));
          end
          `VAPF_ADR_STATUS: next_s.dat = 32'(s.status);
          `VAPF_ADR_MASK: begin
            next_s.dat = 32'(s.mask);
            if (WE_I) next_s.mask = 3'(vapf_merge(32'(s.mask), DAT_I, SEL_I));
          end
          `VAPF_ADR_LEVEL: next_s.dat = 32'(level);
          `VAPF_ADR_READBACK: next_s.dat = s.readback;
          `VAPF_ADR_RATING: next_s.dat = s.rating;
          default: next_s.dat = 32'h0000_0000;
        endcase
      end
    end

    // sticky status, cleared by its read; a new event wins over the clear
    next_s.status = (rd_status ? 3'h0 : s.status) | ev;
    next_s.irq = |(next_s.status & s.mask);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ACK_O = s.ack;
  assign DAT_O = s.dat;
  assign IRQ = s.irq;
  assign Y_ANC = s.y;
  assign Y_ANC_EN = s.y_en;

endmodule : vapf_framer

`default_nettype wire

// *** tb/vapf_framer_asserts.sv ***
// checker of the framer's bus answer and luma insertion ports
// assumes binding to vapf_framer and a bench that drives long blanking intervals
`timescale 1ns/1ps
`default_nettype none
module vapf_framer_asserts (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic [31:0] DAT_O,
  input wire logic HBLANK,
  input wire logic [7:0] Y_ANC,
  input wire logic Y_ANC_EN
);
  logic [3:0] low_cnt;
  // cycles since blanking ended, to allow for the input synchroniser
  always_ff @(posedge CLK) begin
    if (RST || HBLANK) begin
      low_cnt <= 4'h0;
    end else if (low_cnt != 4'hf) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_start;
    $rose(Y_ANC_EN) && Y_ANC == 8'h00;
  endsequence
  a_ack_latency: assert property (s_req |=> ACK_O)
    else $error("bus request not acknowledged after one cycle");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("acknowledge without request");
  a_dat_hold: assert property (!ACK_O |-> $stable(DAT_O))
    else $error("read data changed without acknowledge");
  a_anc_blank: assert property (Y_ANC_EN |-> low_cnt < 4'h6)
    else $error("packet byte outside blanking");
  a_anc_idle: assert property (!Y_ANC_EN |-> Y_ANC == 8'h00)
    else $error("luma byte not zero while idle");
  a_pre_order: assert property ($rose(Y_ANC_EN) |-> Y_ANC == 8'h00)
    else $error("packet does not open with zero byte");
  a_pre_ones: assert property (s_start |-> ##[4:12] Y_ANC == 8'hff)
    else $error("preamble ones byte missing");
  a_byte_hold: assert property (Y_ANC_EN && $changed(Y_ANC) |=> $stable(Y_ANC) [*3])
    else $error("packet byte shorter than a pixel");
endmodule : vapf_framer_asserts
bind vapf_framer vapf_framer_asserts vapf_framer_asserts_inst (
  .CLK(CLK),
  .RST(RST),
  .CYC_I(CYC_I),
  .STB_I(STB_I),
  .ACK_O(ACK_O),
  .DAT_O(DAT_O),
  .HBLANK(HBLANK),
  .Y_ANC(Y_ANC),
  .Y_ANC_EN(Y_ANC_EN)
);
`default_nettype wire

// *** tb/vapf_rx_model.sv ***
// downstream receiver: free running pixel clock, blanking timing, byte capture
// assumes the framer changes a byte a few system clocks after a pixel rise
`timescale 1ns/1ps
`default_nettype none
module vapf_rx_model (
  input wire logic RUN,
  input wire logic [7:0] Y_ANC,
  input wire logic Y_ANC_EN,
  output logic PIX_CLK,
  output logic HBLANK
);
  logic [7:0] got[$];
  int px = 0;
  initial PIX_CLK = 1'b0;
  initial HBLANK = 1'b0;
  always #16 PIX_CLK = ~PIX_CLK;
  // byte of the previous pixel is sampled mid-stream at the next rise
  always @(posedge PIX_CLK) begin
    if (Y_ANC_EN) begin
      got.push_back(Y_ANC);
    end
    px = (px == 79) ? 0 : px + 1;
    // blanking of 60 pixels holds the longest packet whole
    HBLANK <= RUN && px < 60;
  end
endmodule : vapf_rx_model
`default_nettype wire

// *** tb/vapf_framer_tb.sv ***
// bench of the framer: wishbone setup, slicer lines, packet bytes on the luma port
// assumes vapf_pkg compiled first and the receiver model beside it
`timescale 1ns/1ps
`default_nettype none
module vapf_framer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ack, irq, y_en, pix_clk, hblank;
  logic run = 1'b0;
  logic [31:0] dat_o, q;
  logic sl_start = 1'b0, sl_field = 1'b0, sl_m1 = 1'b0, sl_m2 = 1'b0;
  logic sl_bv = 1'b0, sl_end = 1'b0, sl_err = 1'b0;
  logic [9:0] sl_line = 10'h0;
  logic [7:0] sl_byte = 8'h00;
  logic [7:0] y_anc;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  vapf_framer vapf_framer_inst (.CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(dat), .SEL_I(sel), .WE_I(we),
    .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .DAT_O(dat_o), .IRQ(irq), .SL_START(sl_start),
    .SL_LINE(sl_line), .SL_FIELD(sl_field), .SL_MATCH1(sl_m1), .SL_MATCH2(sl_m2),
    .SL_BYTE_VALID(sl_bv), .SL_BYTE(sl_byte), .SL_END(sl_end), .SL_ERROR(sl_err),
    .PIX_CLK(pix_clk), .HBLANK(hblank), .Y_ANC(y_anc), .Y_ANC_EN(y_en));
  vapf_rx_model vapf_rx_model_inst (.RUN(run), .Y_ANC(y_anc), .Y_ANC_EN(y_en), .PIX_CLK(pix_clk),
    .HBLANK(hblank));
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    dat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      num_errors++;
      report_and_stop;
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task send_line(input logic [9:0] ln, input logic f, m1, m2, er, input logic [7:0] base, input int n);
    @(posedge clk);
    sl_start <= 1'b1;
    sl_line <= ln;
    sl_field <= f;
    sl_m1 <= m1;
    sl_m2 <= m2;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sl_start <= 1'b0;
      sl_bv <= 1'b1;
      sl_byte <= base + 8'(i * 7);
    end
    @(posedge clk);
    sl_start <= 1'b0;
    sl_bv <= 1'b0;
    sl_end <= 1'b1;
    sl_err <= er;
    @(posedge clk);
    sl_end <= 1'b0;
  endtask : send_line
  function automatic logic [7:0] pb(input logic [5:0] x);
    return {~(^x), ^x, x};
  endfunction : pb
  task expect_pkt(input logic [9:0] ln, input logic f, m1, m2, er, input logic [2:0] fmt,
                  input logic [7:0] base, input int m);
    logic [7:0] h[$];
    logic [7:0] cs;
    h = {pb({3'h2, f, ln >= 10'd24, 1'b1}), pb({3'h0, fmt}), pb(6'((m + 4) / 4))};
    h.push_back(ln[7:0]);
    h.push_back({3'h0, er, m1, m2, ln[9:8]});
    for (int i = 0; i < m; i++) begin
      h.push_back(base + 8'(i * 7));
    end
    cs = 8'h00;
    foreach (h[i]) begin
      cs += h[i];
    end
    exp_q = {exp_q, 8'h00, 8'hff, 8'hff, h, cs};
    while (exp_q.size() % 4 != 0) begin
      exp_q.push_back(8'h00);
    end
  endtask : expect_pkt
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40};
  int lines[5] = '{5, 30, 10, 25, 21};
  logic [31:0] modes[5] = '{32'h1a, 32'h0b, 32'h19, 32'h09, 32'h06};
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    int n;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(8'h40, 1'b1, 32'hffffffff);
    foreach (ra[i]) begin
      wb(ra[i], 1'b0, 32'h0);
      check(q, 32'h0);
    end
    $display("test reset and unmapped done");
    foreach (lines[i]) begin
      wb(8'h80 + 8'(lines[i] * 4), 1'b1, modes[i]);
    end
    wb(8'h94, 1'b0, 32'h0);
    check(q, 32'h1a);
    wb(8'h08, 1'b1, 32'h1);
    send_line(10'd5, 1'b0, 1'b1, 1'b0, 1'b1, 8'h10, 4);
    expect_pkt(10'd5, 1'b0, 1'b1, 1'b0, 1'b1, 3'h2, 8'h10, 4);
    send_line(10'd30, 1'b1, 1'b0, 1'b1, 1'b0, 8'h30, 5);
    expect_pkt(10'd30, 1'b1, 1'b0, 1'b1, 1'b0, 3'h3, 8'h30, 5);
    send_line(10'd10, 1'b0, 1'b0, 1'b0, 1'b0, 8'h50, 36);
    expect_pkt(10'd10, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 8'h50, 34);
    send_line(10'd25, 1'b0, 1'b0, 1'b0, 1'b0, 8'h70, 10);
    send_line(10'd21, 1'b1, 1'b0, 1'b0, 1'b0, 8'h90, 4);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wb(8'h04, 1'b0, 32'h0);
    check(q, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wb(8'h0c, 1'b0, 32'h0);
    check(q, 32'd76);
    wb(8'h10, 1'b0, 32'h0);
    check(q, 32'h251e1710);
    wb(8'h14, 1'b0, 32'h0);
    check(q, 32'ha59e9790);
    $display("test capture done");
    wb(8'h08, 1'b1, 32'h2);
    wb(8'h00, 1'b1, 32'h1);
    run <= 1'b1;
    n = 0;
    while (vapf_rx_model_inst.got.size() < exp_q.size() && n < 8000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 8000) begin
      num_errors++;
      report_and_stop;
    end
    repeat (200) @(posedge clk);
    check(vapf_rx_model_inst.got.size(), exp_q.size());
    foreach (exp_q[i]) begin
      check(vapf_rx_model_inst.got[i], exp_q[i]);
    end
    wb(8'h0c, 1'b0, 32'h0);
    check(q, 32'h0);
    check(irq, 1'b1);
    wb(8'h04, 1'b0, 32'h0);
    check(q & 32'h2, 32'h2);
    $display("test insertion done");
    report_and_stop;
  end
endmodule : vapf_framer_tb
`default_nettype wire
